// file: logic/eac_pkg.sv
// package for the nvm access block: register offsets, control fields, reset
// values, timing constants and the cpu request carrier.
// assumes a 250 MHz system clock and a cpu that issues one i/o access at a time.
package eac_pkg;

	// i/o offsets (data-space address is the i/o offset plus the data offset)
	localparam logic [5:0] EAC_OFS_GP0 = 6'h0a;
	localparam logic [5:0] EAC_OFS_GP1 = 6'h0b;
	localparam logic [5:0] EAC_OFS_GP2 = 6'h0c;
	localparam logic [5:0] EAC_OFS_CTL = 6'h1c;
	localparam logic [5:0] EAC_OFS_DATA = 6'h1d;
	localparam logic [5:0] EAC_OFS_ADDR_LO = 6'h1e;
	localparam logic [5:0] EAC_OFS_ADDR_HI = 6'h1f;
	localparam logic [6:0] EAC_DS_OFFSET = 7'h20;
	localparam logic [6:0] EAC_IO_SPAN = 7'h40;
	localparam logic [5:0] EAC_BITOP_SPAN = 6'h20;

	// nvm_control field positions
	localparam int EAC_CTL_READ = 0;
	localparam int EAC_CTL_STROBE = 1;
	localparam int EAC_CTL_ARM = 2;
	localparam int EAC_CTL_RIE = 3;
	localparam int EAC_CTL_PM_LO = 4;
	localparam int EAC_CTL_PM_HI = 5;

	// programming modes
	localparam logic [1:0] EAC_PM_ATOMIC = 2'h0;
	localparam logic [1:0] EAC_PM_ERASE = 2'h1;
	localparam logic [1:0] EAC_PM_WRITE = 2'h2;
	localparam logic [1:0] EAC_PM_RSVD = 2'h3;

	// values after reset
	localparam logic [7:0] EAC_RST_BYTE = 8'h00;
	localparam logic [8:0] EAC_RST_ADDR = 9'h000;
	localparam logic [1:0] EAC_RST_MODE = 2'h0;
	localparam logic [7:0] EAC_ERASED = 8'hff;

	// cycle counts
	localparam logic [2:0] EAC_ARM_CYC = 3'h4;
	localparam logic [2:0] EAC_STALL_PROG = 3'h2;
	localparam logic [2:0] EAC_STALL_READ = 3'h4;

	// programming time base: one tick per microsecond from the oscillator divider
	localparam int EAC_CLK_NS = 4;
	localparam int EAC_TICK_NS = 1000;
	localparam int EAC_TICK_CYC = (EAC_TICK_NS + EAC_CLK_NS - 1) / EAC_CLK_NS;
	localparam real EAC_T_ATOMIC_MS = 3.4;
	localparam real EAC_T_SPLIT_MS = 1.8;
	localparam int EAC_ATOMIC_TICKS = int'($ceil(EAC_T_ATOMIC_MS * 1.0e6 / EAC_TICK_NS));
	localparam int EAC_SPLIT_TICKS = int'($ceil(EAC_T_SPLIT_MS * 1.0e6 / EAC_TICK_NS));
	localparam logic [7:0] EAC_DIV_LAST = 8'(EAC_TICK_CYC - 1);

	// cpu i/o request, one cycle per access
	typedef struct packed {
		logic wr;
		logic rd;
		logic bit_op;
		logic bit_val;
		logic [2:0] bit_idx;
		logic data_space;
		logic [6:0] addr;
		logic [7:0] wdata;
	} eac_io_req_t;

	typedef enum logic [1:0] {
		EAC_ST_IDLE,
		EAC_ST_RUN,
		EAC_ST_COMMIT
	} eac_state_t;

endpackage

// file: logic/eac_mem.sv
// byte-wide storage array of 512 locations with a registered read port.
// assumes one access per cycle; write and read never target it together.
`timescale 1ns/1ps
module eac_mem (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [8:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata_q
);

	logic [7:0] cells [0:511];

	// array write, no reset: contents are nonvolatile
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			cells[addr] <= wdata;
		end
	end

	// registered read data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= eac_pkg::EAC_RST_BYTE;
		end else if (rd_en) begin
			rdata_q <= cells[addr];
		end
	end

endmodule

// file: logic/eac_top.sv
// nvm byte access block: address, data and control registers, armed program
// strobe, read strobe, cpu stall, ready interrupt and three scratch registers.
// assumes a same-clock cpu issuing one i/o request per cycle; por_n is the
// supply-good reset that alone may abort a running programming operation.
// Contract
// - nine-bit linear byte address in two registers
// - address high bits seven to one read zero
// - data register feeds writes, receives reads
// - mode selects atomic, erase, write, reserved
// - mode writes ignored while programming
// - reset clears mode unless programming
// - ready interrupt held while enabled and ready
// - arm bit self-clears four cycles later
// - strobe acts only within four armed cycles
// - strobe bit stays set until time elapses
// - program strobe stalls cpu two cycles
// - read strobe fetches byte, stalls four
// - busy refuses reads and address changes
// - running operation survives ordinary reset
// - control bits seven and six read zero
// - bit ops low range, data offset
// - three plain scratch bytes reset zero
// - programming timed from oscillator tick
// - busy rejects all other nvm operations
`timescale 1ns/1ps
module eac_top #(
	parameter int PROG_ATOMIC_TICKS = eac_pkg::EAC_ATOMIC_TICKS,
	parameter int PROG_SPLIT_TICKS = eac_pkg::EAC_SPLIT_TICKS
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic por_n,
	input wire eac_pkg::eac_io_req_t io_req,
	input wire logic cpu_flags_gie,
	output logic [7:0] io_rdata_q,
	output logic cpu_stall_q,
	output logic ready_irq_q
);

	// true when an i/o offset matches a register
	function automatic logic ofs_hit(input logic [5:0] ofs, input logic [5:0] target);
		ofs_hit = (ofs == target);
	endfunction

	// reset synchronisers, asynchronous assert, two-flop release
	logic rst_meta_q;
	logic rst_sync_q;
	logic por_meta_q;
	logic por_sync_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	always_ff @(posedge sys_clk or negedge por_n) begin
		if (!por_n) begin
			por_meta_q <= 1'b0;
			por_sync_q <= 1'b0;
		end else begin
			por_meta_q <= 1'b1;
			por_sync_q <= por_meta_q;
		end
	end

	// register state
	logic [7:0] gp0_q;
	logic [7:0] gp1_q;
	logic [7:0] gp2_q;
	logic [7:0] data_q;
	logic [8:0] addr_q;
	logic [1:0] mode_q;
	logic rie_q;
	logic [2:0] arm_cnt_q;
	logic [2:0] stall_cnt_q;
	logic rd_pend_q;

	// programming engine state, kept across ordinary reset
	eac_pkg::eac_state_t state_q;
	logic [11:0] timer_q;
	logic [7:0] div_q;
	logic [8:0] tgt_addr_q;
	logic [7:0] tgt_data_q;
	logic [1:0] op_mode_q;
	logic [7:0] mem_rdata;

	// address translation: data-space accesses are offset by 0x20
	wire logic [6:0] ds_ofs = io_req.addr - eac_pkg::EAC_DS_OFFSET;
	wire logic ds_ok = (io_req.addr >= eac_pkg::EAC_DS_OFFSET) &&
		(ds_ofs < eac_pkg::EAC_IO_SPAN);
	wire logic io_ok = io_req.addr < eac_pkg::EAC_IO_SPAN;
	wire logic in_range = io_req.data_space ? ds_ok : io_ok;
	wire logic [5:0] ofs = io_req.data_space ? ds_ofs[5:0] : io_req.addr[5:0];

	// register hits
	wire logic hit_gp0 = in_range && ofs_hit(ofs, eac_pkg::EAC_OFS_GP0);
	wire logic hit_gp1 = in_range && ofs_hit(ofs, eac_pkg::EAC_OFS_GP1);
	wire logic hit_gp2 = in_range && ofs_hit(ofs, eac_pkg::EAC_OFS_GP2);
	wire logic hit_ctl = in_range && ofs_hit(ofs, eac_pkg::EAC_OFS_CTL);
	wire logic hit_data = in_range && ofs_hit(ofs, eac_pkg::EAC_OFS_DATA);
	wire logic hit_alo = in_range && ofs_hit(ofs, eac_pkg::EAC_OFS_ADDR_LO);
	wire logic hit_ahi = in_range && ofs_hit(ofs, eac_pkg::EAC_OFS_ADDR_HI);

	// status views
	wire logic busy = (state_q != eac_pkg::EAC_ST_IDLE);
	wire logic arm_active = (arm_cnt_q != 3'h0);

	// control readback: reserved top bits and read strobe read as zero
	wire logic [7:0] ctl_view = {2'b00, mode_q, rie_q, arm_active, busy, 1'b0};

	// read mux, unmapped offsets read zero
	wire logic [7:0] cur_val =
		hit_gp0 ? gp0_q :
		hit_gp1 ? gp1_q :
		hit_gp2 ? gp2_q :
		hit_ctl ? ctl_view :
		hit_data ? data_q :
		hit_alo ? addr_q[7:0] :
		hit_ahi ? {7'h00, addr_q[8]} :
		8'h00;

	// single-bit set and clear as read-modify-write, low i/o range only
	wire logic [7:0] bit_mask = 8'h01 << io_req.bit_idx;
	wire logic bit_ok = io_req.bit_op && (ofs < eac_pkg::EAC_BITOP_SPAN);
	wire logic [7:0] bit_val = io_req.bit_val ? (cur_val | bit_mask) : (cur_val & ~bit_mask);
	wire logic [7:0] wr_val = io_req.bit_op ? bit_val : io_req.wdata;
	wire logic wr_en = rst_sync_q && in_range && (io_req.wr || bit_ok);

	// control write decode
	wire logic ctl_wr = wr_en && hit_ctl;
	wire logic [1:0] wr_mode = {wr_val[eac_pkg::EAC_CTL_PM_HI], wr_val[eac_pkg::EAC_CTL_PM_LO]};
	wire logic mode_wr = ctl_wr && !busy;
	wire logic [1:0] eff_mode = mode_wr ? wr_mode : mode_q;

	// armed strobe starts only when idle and mode is not reserved
	wire logic start = ctl_wr && wr_val[eac_pkg::EAC_CTL_STROBE] && arm_active &&
		!busy && (eff_mode != eac_pkg::EAC_PM_RSVD);
	wire logic read_go = ctl_wr && wr_val[eac_pkg::EAC_CTL_READ] && !busy;
	wire logic addr_open = !busy;

	// oscillator tick: divider runs only during a programming run
	wire logic tick = (div_q == eac_pkg::EAC_DIV_LAST);
	wire logic commit = (state_q == eac_pkg::EAC_ST_COMMIT);

	// programming time per mode
	wire logic [11:0] load_ticks = (eff_mode == eac_pkg::EAC_PM_ATOMIC) ?
		12'(PROG_ATOMIC_TICKS) : 12'(PROG_SPLIT_TICKS);

	// array port: commit writes latched target, otherwise reads current address
	wire logic [8:0] mem_addr = commit ? tgt_addr_q : addr_q;
	wire logic [7:0] mem_wdata = (op_mode_q == eac_pkg::EAC_PM_ERASE) ?
		eac_pkg::EAC_ERASED : tgt_data_q;

	// stall counter next value
	wire logic [2:0] stall_d =
		start ? eac_pkg::EAC_STALL_PROG :
		read_go ? eac_pkg::EAC_STALL_READ :
		(stall_cnt_q != 3'h0) ? stall_cnt_q - 3'h1 : 3'h0;

	// scratch registers, plain storage
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			gp0_q <= eac_pkg::EAC_RST_BYTE;
			gp1_q <= eac_pkg::EAC_RST_BYTE;
			gp2_q <= eac_pkg::EAC_RST_BYTE;
		end else begin
			if (wr_en && hit_gp0) gp0_q <= wr_val;
			if (wr_en && hit_gp1) gp1_q <= wr_val;
			if (wr_en && hit_gp2) gp2_q <= wr_val;
		end
	end

	// address registers, frozen while programming
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			addr_q <= eac_pkg::EAC_RST_ADDR;
		end else begin
			if (wr_en && hit_alo && addr_open) addr_q[7:0] <= wr_val;
			if (wr_en && hit_ahi && addr_open) addr_q[8] <= wr_val[0];
		end
	end

	// data register: fetched byte wins over a cpu write
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			data_q <= eac_pkg::EAC_RST_BYTE;
			rd_pend_q <= 1'b0;
		end else begin
			rd_pend_q <= read_go;
			if (rd_pend_q) begin
				data_q <= mem_rdata;
			end else if (wr_en && hit_data) begin
				data_q <= wr_val;
			end
		end
	end

	// interrupt enable and arm window
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rie_q <= 1'b0;
			arm_cnt_q <= 3'h0;
		end else begin
			if (ctl_wr) rie_q <= wr_val[eac_pkg::EAC_CTL_RIE];
			if (ctl_wr && wr_val[eac_pkg::EAC_CTL_ARM]) begin
				arm_cnt_q <= eac_pkg::EAC_ARM_CYC;
			end else if (arm_active) begin
				arm_cnt_q <= arm_cnt_q - 3'h1;
			end
		end
	end

	// mode field: cleared by ordinary reset only when idle
	always_ff @(posedge sys_clk or negedge por_sync_q) begin
		if (!por_sync_q) begin
			mode_q <= eac_pkg::EAC_RST_MODE;
		end else if (!rst_sync_q && !busy) begin
			mode_q <= eac_pkg::EAC_RST_MODE;
		end else if (mode_wr) begin
			mode_q <= wr_mode;
		end
	end

	// programming engine, reset only by loss of supply
	always_ff @(posedge sys_clk or negedge por_sync_q) begin
		if (!por_sync_q) begin
			state_q <= eac_pkg::EAC_ST_IDLE;
			timer_q <= 12'h000;
			div_q <= 8'h00;
			tgt_addr_q <= eac_pkg::EAC_RST_ADDR;
			tgt_data_q <= eac_pkg::EAC_RST_BYTE;
			op_mode_q <= eac_pkg::EAC_RST_MODE;
		end else begin
			unique case (state_q)
				eac_pkg::EAC_ST_IDLE: begin
					if (start) begin
						state_q <= eac_pkg::EAC_ST_RUN;
						timer_q <= load_ticks;
						div_q <= 8'h00;
						tgt_addr_q <= addr_q;
						tgt_data_q <= data_q;
						op_mode_q <= eac_mode_sel(eff_mode);
					end
				end
				eac_pkg::EAC_ST_RUN: begin
					// keeps running through ordinary reset
					div_q <= tick ? 8'h00 : div_q + 8'h01;
					if (tick) begin
						timer_q <= timer_q - 12'h001;
						if (timer_q == 12'h001) state_q <= eac_pkg::EAC_ST_COMMIT;
					end
				end
				eac_pkg::EAC_ST_COMMIT: begin
					state_q <= eac_pkg::EAC_ST_IDLE;
				end
			endcase
		end
	end

	// operation latched at start; kept as a function for the readable mode map
	function automatic logic [1:0] eac_mode_sel(input logic [1:0] m);
		eac_mode_sel = m;
	endfunction

	// cpu-facing outputs
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			io_rdata_q <= 8'h00;
			stall_cnt_q <= 3'h0;
			cpu_stall_q <= 1'b0;
			ready_irq_q <= 1'b0;
		end else begin
			if (io_req.rd) io_rdata_q <= cur_val;
			stall_cnt_q <= stall_d;
			cpu_stall_q <= (stall_d != 3'h0);
			ready_irq_q <= rie_q && cpu_flags_gie && !busy;
		end
	end

	// storage array
	eac_mem u_mem (
		.sys_clk(sys_clk),
		.rst_n(por_sync_q),
		.wr_en(commit),
		.rd_en(read_go),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata_q(mem_rdata)
	);

endmodule

// file: dv/eac_cpu_model.sv
// cpu model: issues one io request at a time and waits out the stall.
// assumes the block takes a request at the edge after it is driven.
`timescale 1ns/1ps
module eac_cpu_model (
	input wire logic sys_clk,
	input wire logic cpu_stall_q,
	output eac_pkg::eac_io_req_t io_req
);
	initial io_req = '0;
	// one-cycle request, idle fields inverted afterwards, then stall wait
	task automatic req(input logic w, input logic r, input logic b, input logic [2:0] ix,
		input logic [6:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		io_req <= '{w, r, b, d[0], ix, a[5] | a[6], a, d};
		@(posedge sys_clk);
		io_req <= '{1'b0, 1'b0, 1'b0, ~d[0], ~ix, ~a[5], ~a, ~d};
		for (int i = 0; i < 8 && (i == 0 || cpu_stall_q !== 1'b0); i++) @(posedge sys_clk);
	endtask
endmodule

// file: dv/eac_top_sva.sv
// checker for the nvm access block: stall, ready interrupt and readback.
// assumes only the top ports; bound to the top at the foot of this file.
`timescale 1ns/1ps
module eac_top_sva #(
	parameter int PROG_ATOMIC_TICKS = 3400,
	parameter int PROG_SPLIT_TICKS = 1800
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic por_n,
	input wire eac_pkg::eac_io_req_t io_req,
	input wire logic cpu_flags_gie,
	input wire logic [7:0] io_rdata_q,
	input wire logic cpu_stall_q,
	input wire logic ready_irq_q
);
	// register selects in either address space
	wire logic [6:0] io_a = io_req.addr - (io_req.data_space ? eac_pkg::EAC_DS_OFFSET : 7'h00);
	wire logic ctl_sel = io_a == {1'b0, eac_pkg::EAC_OFS_CTL};
	wire logic hi_sel = io_a == {1'b0, eac_pkg::EAC_OFS_ADDR_HI};
	wire logic ctl_hit = (io_req.wr || io_req.bit_op) && ctl_sel;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n || !por_n);
	a_stall_span: assert property ($rose(cpu_stall_q) |->
		cpu_stall_q ##1 cpu_stall_q ##[1:3] !cpu_stall_q) else $error("stall span wrong");
	a_read_stall: assert property (io_req.wr && ctl_sel && io_req.wdata[1:0] == 2'b01 &&
		ready_irq_q && !cpu_stall_q |=> cpu_stall_q [*4] ##1 !cpu_stall_q)
		else $error("read stall not four cycles");
	a_irq_gie: assert property (!cpu_flags_gie |=> !ready_irq_q) else $error("irq without gie");
	// a control write lands in rie one edge before the interrupt register sees it
	a_irq_hold: assert property (ready_irq_q && cpu_flags_gie && !$past(ctl_hit) &&
		!cpu_stall_q
		|=> ready_irq_q) else $error("ready irq dropped while idle");
	a_irq_drop: assert property ($rose(cpu_stall_q) ##1 cpu_stall_q ##1 !cpu_stall_q
		|-> !ready_irq_q) else $error("ready irq high while programming");
	a_rdata_hold: assert property (!io_req.rd |=> $stable(io_rdata_q))
		else $error("read data moved without read");
	a_rsvd_hi: assert property (io_req.rd && hi_sel |=> io_rdata_q[7:1] == 7'h00)
		else $error("address high reserved bits set");
	a_rsvd_ctl: assert property (io_req.rd && ctl_sel |=> io_rdata_q[7:6] == 2'h0
		&& !io_rdata_q[0]) else $error("control reserved bits set");
	a_reset_quiet: assert property (@(posedge sys_clk) disable iff (!por_n)
		!reset_n |-> !cpu_stall_q && !ready_irq_q) else $error("outputs active in reset");
	c_prog: cover property ($rose(cpu_stall_q) ##1 cpu_stall_q ##1 !cpu_stall_q);
	c_read: cover property (cpu_stall_q [*4]);
	c_irq: cover property ($rose(ready_irq_q));
endmodule
bind eac_top eac_top_sva #(.PROG_ATOMIC_TICKS(PROG_ATOMIC_TICKS),
	.PROG_SPLIT_TICKS(PROG_SPLIT_TICKS)) chk_u (.sys_clk(sys_clk), .reset_n(reset_n),
	.por_n(por_n), .io_req(io_req), .cpu_flags_gie(cpu_flags_gie), .io_rdata_q(io_rdata_q),
	.cpu_stall_q(cpu_stall_q), .ready_irq_q(ready_irq_q));

// file: dv/test_eac_top.sv
// testbench for the nvm access block: registers, programming, reads, reset.
// assumes the cpu model drives the request port; short tick counts.
`timescale 1ns/1ps
module test_eac_top;
	localparam int AT = 3;
	localparam int ST = 2;
	localparam logic [6:0] CTL = 7'h1c;
	localparam logic [6:0] DAT = 7'h1d;
	localparam logic [6:0] ALO = 7'h1e;
	localparam logic [6:0] AHI = 7'h1f;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic por_n = 1'b0;
	logic cpu_flags_gie = 1'b0;
	logic [7:0] io_rdata_q;
	logic cpu_stall_q;
	logic ready_irq_q;
	logic rd_q = 1'b0;
	eac_pkg::eac_io_req_t io_req;
	logic [7:0] exp_q[$];
	logic [7:0] v;
	logic [7:0] e;
	logic [31:0] seed = 32'h7640_672d;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	int t0;
	int tk;
	always #2 sys_clk = ~sys_clk;
	eac_cpu_model cpu_u (.sys_clk(sys_clk), .cpu_stall_q(cpu_stall_q), .io_req(io_req));
	eac_top #(.PROG_ATOMIC_TICKS(AT), .PROG_SPLIT_TICKS(ST)) dut_u (.sys_clk(sys_clk),
		.reset_n(reset_n), .por_n(por_n), .io_req(io_req), .cpu_flags_gie(cpu_flags_gie),
		.io_rdata_q(io_rdata_q), .cpu_stall_q(cpu_stall_q), .ready_irq_q(ready_irq_q));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] x);
		checked++;
		if (s !== x) begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", n, x, s);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		cpu_u.req(1'b1, 1'b0, 1'b0, 3'h0, a, d);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		cpu_u.req(1'b0, 1'b1, 1'b0, 3'h0, a, 8'h00);
	endtask
	task automatic bump_reset();
		reset_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
		wr(ALO, a[7:0]);
		wr(AHI, {7'h00, a[8]});
		wr(DAT, d);
		wr(CTL, {2'b00, m, 4'b1100});
		wr(CTL, {2'b00, m, 4'b1010});
	endtask
	task automatic wait_ready();
		for (int n = 0; n < 3000 && ready_irq_q !== 1'b1; n++) @(posedge sys_clk);
	endtask
	task automatic rd_byte(input logic [8:0] a, input logic [7:0] x);
		wr(ALO, a[7:0]);
		wr(AHI, {7'h00, a[8]});
		wr(CTL, 8'h09);
		rd(DAT, x);
	endtask
	// cycle count and read answer comparison against the oldest note
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (rd_q && exp_q.size() > 0)
			check("rdata", io_rdata_q, exp_q.pop_front());
		rd_q <= io_req.rd;
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		conclude();
	end
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		por_n <= 1'b1;
		cpu_flags_gie <= 1'b1;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 3; i++) begin
			v = 8'(rnd());
			rd(7'h0a + 7'(i), 8'h00);
			wr(7'h2a + 7'(i), v);
			rd(7'h0a + 7'(i), v);
			cpu_u.req(1'b0, 1'b0, 1'b1, 3'(i), 7'h0a + 7'(i), 8'h01);
			v[i] = 1'b1;
			rd(7'h2a + 7'(i), v);
			cpu_u.req(1'b0, 1'b0, 1'b1, 3'(i + 4), 7'h0a + 7'(i), 8'h00);
			v[i + 4] = 1'b0;
			rd(7'h0a + 7'(i), v);
		end
		rd(7'h05, 8'h00);
		wr(ALO, 8'h5a);
		wr(AHI, 8'h01);
		rd(AHI, 8'h01);
		rd(ALO, 8'h5a);
		wr(CTL, 8'h0c);
		rd(CTL, 8'h0c);
		repeat (4) @(posedge sys_clk);
		rd(CTL, 8'h08);
		wr(CTL, 8'h0a);
		check("idle", {7'h00, ready_irq_q}, 8'h01);
		rd(CTL, 8'h08);
		for (int k = 0; k < 4; k++) begin
			v = 8'(rnd());
			e = (k == 1) ? 8'hff : v;
			tk = (k == 0) ? AT : ST;
			prog(2'(k), 9'h1a5, v);
			t0 = cyc;
			if (k == 3) begin
				check("rsvd", {7'h00, ready_irq_q}, 8'h01);
				rd(CTL, 8'h38);
			end else begin
				if (k == 0) begin
					wr(CTL, 8'h28);
					wr(ALO, 8'h00);
					wr(CTL, 8'h09);
					check("irq", {7'h00, ready_irq_q}, 8'h00);
					rd(CTL, 8'h0a);
					rd(ALO, 8'ha5);
					rd(DAT, v);
				end
				wait_ready();
				check("time", 8'(cyc - t0 >= tk * 250 - 252 && cyc - t0 <= tk * 250 + 8),
					8'h01);
				rd_byte(9'h1a5, e);
			end
		end
		prog(2'b01, 9'h0c3, 8'h00);
		bump_reset();
		rd(CTL, 8'h12);
		wr(CTL, 8'h18);
		wait_ready();
		rd_byte(9'h0c3, 8'hff);
		wr(CTL, 8'h20);
		bump_reset();
		rd(CTL, 8'h00);
		wr(CTL, 8'h08);
		cpu_flags_gie <= 1'b0;
		repeat (3) @(posedge sys_clk);
		check("gie", {7'h00, ready_irq_q}, 8'h00);
		conclude();
	end
endmodule
